// file: rtl/pin_select_defines.svh
// Offsets, field positions, reset values and bus codes for the pin select registers.
// Assumes a 32-bit AXI4-Lite bus, one aligned word per register.
`ifndef PIN_SELECT_DEFINES_SVH
`define PIN_SELECT_DEFINES_SVH

`define SPI2_CD_SEL_OFFSET   32'h0000_0000
`define SPI2_SS_SEL_OFFSET   32'h0000_0004
`define UART4_SEL_OFFSET     32'h0000_0008
`define SPI3_CD_SEL_OFFSET   32'h0000_000C
`define SPI3_SS_SEL_OFFSET   32'h0000_0010
`define PINS_0_1_OFFSET      32'h0000_0014
`define PINS_2_3_OFFSET      32'h0000_0018
`define PINS_4_5_OFFSET      32'h0000_001C

`define LOW_FIELD_LSB        0
`define HIGH_FIELD_LSB       8
`define FIRST_OUTPUT_INDEX   3'h5
`define SPI2_SS_INDEX        3'h1
`define SPI3_SS_INDEX        3'h4
`define PINS_4_5_INDEX       3'h7

`define IN_SEL_RESET         6'h3F
`define OUT_FUNC_RESET       6'h00

`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2

`endif

// file: rtl/pin_select_pkg.sv
// Types shared by the pin select register block.
// Assumes the constants of pin_select_defines.svh.
package pin_select_pkg;

  typedef logic [5:0] pin_sel_type;

  typedef struct packed {
    pin_sel_type high;
    pin_sel_type low;
  } sel_pair_type;

  typedef struct packed {
    logic       valid;
    logic [2:0] index;
  } reg_hit_type;

  typedef enum logic [1:0] {
    CH_IDLE = 2'h0,
    CH_TAKE = 2'h1,
    CH_RESP = 2'h2
  } chan_state_type;

endpackage : pin_select_pkg

// file: rtl/remappable_pin_select_regs.sv
// Remappable pin select registers with AXI4-Lite access and the routing muxes.
// Assumes pins arrive asynchronously and output functions come from aclk logic.
`include "pin_select_defines.svh"

module remappable_pin_select_regs #(
  parameter bit small_package = 1'b0
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [31:0] araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic [63:0] remappable_pin_in,
  input  wire logic [63:0] periph_func_out,
  output logic             port2_clock_input,
  output logic             port2_data_input,
  output logic             port2_slave_select_input,
  output logic             uart4_cts_input,
  output logic             uart4_rx_input,
  output logic             port3_clock_input,
  output logic             port3_data_input,
  output logic             port3_slave_select_input,
  output logic [5:0]       remappable_io_pin_out
);

  function automatic pin_select_pkg::reg_hit_type decode(input logic [31:0] addr);
    pin_select_pkg::reg_hit_type hit;
    hit.valid = 1'b1;
    hit.index = 3'h0;
    unique case (addr)
      `SPI2_CD_SEL_OFFSET: hit.index = 3'h0;
      `SPI2_SS_SEL_OFFSET: hit.index = 3'h1;
      `UART4_SEL_OFFSET:   hit.index = 3'h2;
      `SPI3_CD_SEL_OFFSET: hit.index = 3'h3;
      `SPI3_SS_SEL_OFFSET: hit.index = 3'h4;
      `PINS_0_1_OFFSET:    hit.index = 3'h5;
      `PINS_2_3_OFFSET:    hit.index = 3'h6;
      `PINS_4_5_OFFSET:    hit.index = 3'h7;
      default:             hit.valid = 1'b0;
    endcase
    return hit;
  endfunction : decode

  // Slave-select registers hold one field; pin five is absent on the small package
  function automatic logic has_high(input logic [2:0] idx);
    return !(idx == `SPI2_SS_INDEX || idx == `SPI3_SS_INDEX ||
             (small_package && idx == `PINS_4_5_INDEX));
  endfunction : has_high

  function automatic pin_select_pkg::sel_pair_type reset_pair(input logic [2:0] idx);
    pin_select_pkg::pin_sel_type v;
    v = (idx < `FIRST_OUTPUT_INDEX) ? `IN_SEL_RESET : `OUT_FUNC_RESET;
    return '{high: has_high(idx) ? v : `OUT_FUNC_RESET, low: v};
  endfunction : reset_pair

  // Pin synchroniser; only the second stage feeds the muxes
  logic [63:0] pin_meta_q;
  logic [63:0] pin_sync_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_q <= 64'h0;
      pin_sync_q <= 64'h0;
    end else begin
      pin_meta_q <= remappable_pin_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  // Register file and bus channels
  pin_select_pkg::sel_pair_type   regs_q [8];
  pin_select_pkg::sel_pair_type   regs_d [8];
  pin_select_pkg::chan_state_type wr_state_q, wr_state_d;
  pin_select_pkg::chan_state_type rd_state_q, rd_state_d;
  pin_select_pkg::reg_hit_type    wr_hit;
  pin_select_pkg::reg_hit_type    rd_hit;
  logic        awready_q, awready_d;
  logic        wready_q,  wready_d;
  logic        bvalid_q,  bvalid_d;
  logic [1:0]  bresp_q,   bresp_d;
  logic        arready_q, arready_d;
  logic        rvalid_q,  rvalid_d;
  logic [1:0]  rresp_q,   rresp_d;
  logic [31:0] rdata_q,   rdata_d;

  always_comb begin
    wr_hit     = decode(awaddr);
    rd_hit     = decode(araddr);
    regs_d     = regs_q;
    wr_state_d = wr_state_q;
    awready_d  = 1'b0;
    wready_d   = 1'b0;
    bvalid_d   = bvalid_q;
    bresp_d    = bresp_q;
    // Waiting for both channels keeps address and data paired without holding buffers
    unique case (wr_state_q)
      pin_select_pkg::CH_IDLE: begin
        if (awvalid && wvalid) begin
          awready_d  = 1'b1;
          wready_d   = 1'b1;
          wr_state_d = pin_select_pkg::CH_TAKE;
        end
      end
      pin_select_pkg::CH_TAKE: begin
        if (wr_hit.valid) begin
          if (wstrb[0]) begin
            regs_d[wr_hit.index].low = wdata[`LOW_FIELD_LSB +: 6];
          end
          if (wstrb[1] && has_high(wr_hit.index)) begin
            regs_d[wr_hit.index].high = wdata[`HIGH_FIELD_LSB +: 6];
          end
        end
        bresp_d    = wr_hit.valid ? `RESP_OKAY : `RESP_SLVERR;
        bvalid_d   = 1'b1;
        wr_state_d = pin_select_pkg::CH_RESP;
      end
      pin_select_pkg::CH_RESP: begin
        if (bready) begin
          bvalid_d   = 1'b0;
          wr_state_d = pin_select_pkg::CH_IDLE;
        end
      end
      default: wr_state_d = pin_select_pkg::CH_IDLE;
    endcase
  end

  always_comb begin
    rd_state_d = rd_state_q;
    arready_d  = 1'b0;
    rvalid_d   = rvalid_q;
    rresp_d    = rresp_q;
    rdata_d    = rdata_q;
    unique case (rd_state_q)
      pin_select_pkg::CH_IDLE: begin
        if (arvalid) begin
          arready_d  = 1'b1;
          rd_state_d = pin_select_pkg::CH_TAKE;
        end
      end
      pin_select_pkg::CH_TAKE: begin
        rdata_d = 32'h0;
        if (rd_hit.valid) begin
          rdata_d[`LOW_FIELD_LSB +: 6]  = regs_q[rd_hit.index].low;
          rdata_d[`HIGH_FIELD_LSB +: 6] = regs_q[rd_hit.index].high;
        end
        rresp_d    = rd_hit.valid ? `RESP_OKAY : `RESP_SLVERR;
        rvalid_d   = 1'b1;
        rd_state_d = pin_select_pkg::CH_RESP;
      end
      pin_select_pkg::CH_RESP: begin
        if (rready) begin
          rvalid_d   = 1'b0;
          rd_state_d = pin_select_pkg::CH_IDLE;
        end
      end
      default: rd_state_d = pin_select_pkg::CH_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 8; i++) begin
        regs_q[i] <= reset_pair(3'(i));
      end
      wr_state_q <= pin_select_pkg::CH_IDLE;
      rd_state_q <= pin_select_pkg::CH_IDLE;
      awready_q  <= 1'b0;
      wready_q   <= 1'b0;
      bvalid_q   <= 1'b0;
      bresp_q    <= `RESP_OKAY;
      arready_q  <= 1'b0;
      rvalid_q   <= 1'b0;
      rresp_q    <= `RESP_OKAY;
      rdata_q    <= 32'h0;
    end else begin
      regs_q     <= regs_d;
      wr_state_q <= wr_state_d;
      rd_state_q <= rd_state_d;
      awready_q  <= awready_d;
      wready_q   <= wready_d;
      bvalid_q   <= bvalid_d;
      bresp_q    <= bresp_d;
      arready_q  <= arready_d;
      rvalid_q   <= rvalid_d;
      rresp_q    <= rresp_d;
      rdata_q    <= rdata_d;
    end
  end

  // Routing muxes; registering them means a new selection switches cleanly
  // one edge after the register update, never through a partial code
  logic [7:0] periph_in_q, periph_in_d;
  logic [5:0] pin_out_q,   pin_out_d;

  always_comb begin
    periph_in_d[0] = pin_sync_q[regs_q[0].high];
    periph_in_d[1] = pin_sync_q[regs_q[0].low];
    periph_in_d[2] = pin_sync_q[regs_q[1].low];
    periph_in_d[3] = pin_sync_q[regs_q[2].high];
    periph_in_d[4] = pin_sync_q[regs_q[2].low];
    periph_in_d[5] = pin_sync_q[regs_q[3].high];
    periph_in_d[6] = pin_sync_q[regs_q[3].low];
    periph_in_d[7] = pin_sync_q[regs_q[4].low];
    for (int p = 0; p < 3; p++) begin
      pin_out_d[2 * p]     = periph_func_out[regs_q[5 + p].low];
      pin_out_d[2 * p + 1] = periph_func_out[regs_q[5 + p].high];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      periph_in_q <= 8'h00;
      pin_out_q   <= 6'h00;
    end else begin
      periph_in_q <= periph_in_d;
      pin_out_q   <= pin_out_d;
    end
  end

  assign awready                  = awready_q;
  assign wready                   = wready_q;
  assign bvalid                   = bvalid_q;
  assign bresp                    = bresp_q;
  assign arready                  = arready_q;
  assign rvalid                   = rvalid_q;
  assign rresp                    = rresp_q;
  assign rdata                    = rdata_q;
  assign port2_clock_input        = periph_in_q[0];
  assign port2_data_input         = periph_in_q[1];
  assign port2_slave_select_input = periph_in_q[2];
  assign uart4_cts_input          = periph_in_q[3];
  assign uart4_rx_input           = periph_in_q[4];
  assign port3_clock_input        = periph_in_q[5];
  assign port3_data_input         = periph_in_q[6];
  assign port3_slave_select_input = periph_in_q[7];
  assign remappable_io_pin_out    = pin_out_q;

endmodule : remappable_pin_select_regs

// file: testbench/remappable_pin_select_regs_monitor.sv
// Checker watching the pin select register block at its ports.
// Assumes it is bound into every remappable_pin_select_regs.
module remappable_pin_select_regs_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awready,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        arready,
  input wire logic [31:0] araddr,
  input wire logic        rvalid,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic [63:0] remappable_pin_in,
  input wire logic [63:0] periph_func_out,
  input wire logic        port2_clock_input,
  input wire logic [5:0]  remappable_io_pin_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] ra_q, ra_d;
  logic        wr_q, wr_d;
  // Address is gone after the handshake, so keep it for the reply
  always_comb begin
    ra_d = arready ? araddr : ra_q;
    wr_d = wr_q | awready;
  end
  always_ff @(posedge aclk) begin
    ra_q <= aresetn ? ra_d : 32'h0;
    wr_q <= aresetn & wr_d;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_wr; awready |-> wready ##1 bvalid; endproperty
  a_wr: assert property (p_wr) else $error("write reply late");
  property p_rd; arready |=> rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read reply late");
  property p_gap; rvalid |-> rdata[31:14] == 18'h0 && rdata[7:6] == 2'h0; endproperty
  a_gap: assert property (p_gap) else $error("unused bits set");
  property p_ss; rvalid && (ra_q == 32'h4 || ra_q == 32'h10) |-> rdata[15:6] == 10'h0;
  endproperty
  a_ss: assert property (p_ss) else $error("select upper bits set");
  property p_miss; rvalid && ra_q > 32'h1C |-> rresp == 2'h2 && rdata == 32'h0; endproperty
  a_miss: assert property (p_miss) else $error("unmapped read");
  property p_in0; rvalid && !wr_q && ra_q < 32'h14 |-> rdata[5:0] == 6'h3F; endproperty
  a_in0: assert property (p_in0) else $error("input reset value");
  property p_out0; rvalid && !wr_q && ra_q >= 32'h14 && ra_q <= 32'h1C |-> rdata == 32'h0;
  endproperty
  a_out0: assert property (p_out0) else $error("output reset value");
  property p_pin; (remappable_pin_in == '1) [*4] |-> port2_clock_input; endproperty
  a_pin: assert property (p_pin) else $error("input route");
  property p_func; (periph_func_out == '1) [*2] |-> remappable_io_pin_out == 6'h3F; endproperty
  a_func: assert property (p_func) else $error("output route");
  c_wr: cover property (awready);
  c_miss: cover property (rvalid && rresp == 2'h2);
  c_func: cover property (remappable_io_pin_out == 6'h3F);
endmodule : remappable_pin_select_regs_monitor

bind remappable_pin_select_regs remappable_pin_select_regs_monitor u_monitor (.*);

// file: testbench/remappable_pin_select_regs_bench.sv
// Self-checking bench for the remappable pin select register block.
// Assumes the AXI4-Lite timing and pin synchroniser depth of the block.
module remappable_pin_select_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, d, ds;
  logic [3:0] wstrb = 4'hF;
  logic [63:0] remappable_pin_in = 64'h0, periph_func_out = 64'h0;
  logic [1:0] r;
  wire awready, wready, bvalid, arready, rvalid, port2_clock_input, port2_data_input;
  wire port2_slave_select_input, uart4_cts_input, uart4_rx_input, port3_clock_input;
  wire port3_data_input, port3_slave_select_input;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [5:0] remappable_io_pin_out;
  wire [31:0] small_rdata;
  wire [5:0] small_pin_out;
  wire [7:0] ins = {port2_clock_input, port2_data_input, port2_slave_select_input,
    uart4_cts_input, uart4_rx_input, port3_clock_input, port3_data_input,
    port3_slave_select_input};
  int n_errors = 0, total_checks = 0;
  remappable_pin_select_regs u_remappable_pin_select_regs (.*, .awprot(3'h0), .arprot(3'h0));
  // Second copy without pin five's field; same stimulus, so its replies line up
  remappable_pin_select_regs #(.small_package(1'b1)) u_remappable_pin_select_regs_small (
    .*, .awprot(3'h0), .arprot(3'h0),
    .awready(), .wready(), .bresp(), .bvalid(), .arready(),
    .rdata(small_rdata), .rresp(), .rvalid(),
    .port2_clock_input(), .port2_data_input(), .port2_slave_select_input(),
    .uart4_cts_input(), .uart4_rx_input(), .port3_clock_input(),
    .port3_data_input(), .port3_slave_select_input(),
    .remappable_io_pin_out(small_pin_out)
  );
  always #20 aclk = ~aclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic [3:0] s);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    ds = small_rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic t_reset;
    for (int i = 0; i < 9; i++) begin
      rd(32'(i * 4));
      chk(d, i > 4 ? 32'h0 : (i == 1 || i == 4) ? 32'h3F : 32'h3F3F);
      chk(32'(r), i > 7 ? 32'h2 : 32'h0);
    end
    $display("t_reset done");
  endtask : t_reset
  task automatic t_rw;
    for (int i = 0; i < 8; i++) begin
      wr(32'(i * 4), 32'hFFFF_FFFF, 4'hF);
      rd(32'(i * 4));
      chk(d, (i == 1 || i == 4) ? 32'h3F : 32'h3F3F);
      chk(ds, (i == 1 || i == 4 || i == 7) ? 32'h3F : 32'h3F3F);
    end
    // Strobe on the upper lane only: low field must survive
    wr(32'h0, 32'h0, 4'h2);
    rd(32'h0);
    chk(d, 32'h3F);
    wr(32'h40, 32'h0, 4'hF);
    chk(32'(r), 32'h2);
    $display("t_rw done");
  endtask : t_rw
  task automatic t_in_route;
    wr(32'h0, 32'h0A0B, 4'hF);
    wr(32'h4, 32'h0C, 4'hF);
    wr(32'h8, 32'h0D0E, 4'hF);
    wr(32'hC, 32'h0F10, 4'hF);
    wr(32'h10, 32'h11, 4'hF);
    for (int k = 0; k < 9; k++) begin
      remappable_pin_in <= k > 7 ? '1 : 64'h1 << (10 + k);
      repeat (5) @(posedge aclk);
      chk(32'(ins), k > 7 ? 32'hFF : 32'h80 >> k);
    end
    $display("t_in_route done");
  endtask : t_in_route
  task automatic t_out_route;
    for (int i = 0; i < 3; i++) begin
      wr(32'(20 + i * 4), 32'h1514 + 32'(i) * 32'h0202, 4'hF);
    end
    for (int k = 0; k < 7; k++) begin
      periph_func_out <= k > 5 ? '1 : 64'h1 << (20 + k);
      repeat (3) @(posedge aclk);
      chk(32'(remappable_io_pin_out), k > 5 ? 32'h3F : 32'h1 << k);
      chk(32'(small_pin_out), k > 5 ? 32'h3F : k == 5 ? 32'h0 : 32'h1 << k);
    end
    periph_func_out <= 64'h1 << 20;
    wr(32'h14, 32'h1415, 4'hF);
    // Old routing still stands as the reply arrives, new one one edge later
    chk(32'(remappable_io_pin_out), 32'h1);
    @(posedge aclk);
    chk(32'(remappable_io_pin_out), 32'h2);
    $display("t_out_route done");
  endtask : t_out_route
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (5000) @(posedge aclk);
    n_errors++;
    tally_and_finish;
  end
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_rw;
    t_in_route;
    t_out_route;
    tally_and_finish;
  end
endmodule : remappable_pin_select_regs_bench
